// *** shared/spfs_pkg.sv ***
// Constants for the second multi-function pin selector: register map,
// field layout, function codes and pulse timing.
// Assumes a 25 MHz core clock shared with the codec control logic.
//
// Behaviour
// - Function code zero leaves pin disabled
// - Code 0010 drives headset detect interrupt pulse
// - Code 0011 samples pin as general input
// - Code 0100 drives output value bit
// - Codes 0101-0111 capture microphone data both edges
// - Code 1000 pin is serial bit clock
// - Code 1001 ORs headset and button interrupts
// - Code 1010 ORs all four interrupts
// - Code 1011 ORs short-circuit and noise interrupts
// - Code 1100 ORs short-circuit and button interrupts
// - Code 1101 drives short-circuit interrupt alone
// - Code 1110 drives noise interrupt alone
// - Code 1111 drives button interrupt alone
// - Bit 3 sets output level, resets low
// - Bit 2 reads the pin level
// - Bit 1 clear gives one pulse, 2ms, or 1.75ms for headset detect
// - Bit 1 set repeats pulses until flags read

`default_nettype none

package spfs_pkg;
   // Register map
   localparam logic [7:0] CTRL_ADDR = 8'h63;
   localparam logic [7:0] FLAGS_ADDR = 8'h60;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] CTRL_WR_MASK = 8'hFA;
   // Field positions
   localparam int FUNC_MSB = 7;
   localparam int FUNC_LSB = 4;
   localparam int OUT_BIT = 3;
   localparam int IN_BIT = 2;
   localparam int DUR_BIT = 1;
   localparam int RSVD_BIT = 0;
   // Function codes
   localparam logic [3:0] FN_DISABLED = 4'h0;
   localparam logic [3:0] FN_RESERVED = 4'h1;
   localparam logic [3:0] FN_HEADSET = 4'h2;
   localparam logic [3:0] FN_GP_IN = 4'h3;
   localparam logic [3:0] FN_GP_OUT = 4'h4;
   localparam logic [3:0] FN_MIC_LO = 4'h5;
   localparam logic [3:0] FN_MIC_HI = 4'h7;
   localparam logic [3:0] FN_BIT_CLK = 4'h8;
   localparam logic [3:0] FN_HS_BTN = 4'h9;
   localparam logic [3:0] FN_ALL = 4'hA;
   localparam logic [3:0] FN_SC_NOISE = 4'hB;
   localparam logic [3:0] FN_SC_BTN = 4'hC;
   localparam logic [3:0] FN_SC = 4'hD;
   localparam logic [3:0] FN_NOISE = 4'hE;
   localparam logic [3:0] FN_BTN = 4'hF;
   // Timing
   localparam int CLK_KHZ = 25000;
   localparam real HEADSET_PULSE_MS = 1.75;
   localparam real IRQ_PULSE_MS = 2.0;
   localparam int HEADSET_PULSE_CYC = int'($floor(HEADSET_PULSE_MS * CLK_KHZ));
   localparam int IRQ_PULSE_CYC = int'($floor(IRQ_PULSE_MS * CLK_KHZ));
   localparam int CNT_W = 16;
   // Pulse sequencer states
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b001,
      ST_PULSE = 3'b010,
      ST_GAP = 3'b100
   } spfs_state_e;
endpackage

`default_nettype wire

// *** rtl/spfs_pin_ctrl.sv ***
// Control register and pin function mux for the second multi-function pin.
// Assumes register accesses, interrupt events, microphone clock and bit clock
// come from logic on clk; only the pin level is asynchronous.

`default_nettype none

module spfs_pin_ctrl
#(
   parameter int HEADSET_LEN = spfs_pkg::HEADSET_PULSE_CYC,
   parameter int PULSE_LEN = spfs_pkg::IRQ_PULSE_CYC
)
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clkEn,
   input wire logic [7:0] regAddr,
   input wire logic regWrEn,
   input wire logic [7:0] regWrData,
   input wire logic regRdEn,
   output logic [7:0] regRdData,
   input wire logic headsetIrq,
   input wire logic buttonIrq,
   input wire logic shortIrq,
   input wire logic noiseIrq,
   input wire logic micClk,
   output logic micDataRise,
   output logic micDataFall,
   input wire logic bitClkOut,
   input wire logic bitClkMaster,
   output logic bitClkIn,
   input wire logic pinIn,
   output logic pinOut,
   output logic pinOeN
);

   // Input functions never drive the pin
   function automatic logic isInputFn(input logic [3:0] fn);
      isInputFn = (fn == spfs_pkg::FN_DISABLED) || (fn == spfs_pkg::FN_RESERVED) ||
                  (fn == spfs_pkg::FN_GP_IN) ||
                  ((fn >= spfs_pkg::FN_MIC_LO) && (fn <= spfs_pkg::FN_MIC_HI));
   endfunction

   // Interrupt sources selected by a function code
   function automatic logic irqSelect(input logic [3:0] fn, input logic hs, input logic bt,
                                      input logic sc, input logic ng);
      case (fn)
         spfs_pkg::FN_HEADSET: irqSelect = hs;
         spfs_pkg::FN_HS_BTN: irqSelect = hs | bt;
         spfs_pkg::FN_ALL: irqSelect = hs | bt | sc | ng;
         spfs_pkg::FN_SC_NOISE: irqSelect = sc | ng;
         spfs_pkg::FN_SC_BTN: irqSelect = sc | bt;
         spfs_pkg::FN_SC: irqSelect = sc;
         spfs_pkg::FN_NOISE: irqSelect = ng;
         spfs_pkg::FN_BTN: irqSelect = bt;
         default: irqSelect = 1'b0;
      endcase
   endfunction

   logic [7:0] ctrl_reg;
   logic [7:0] rdData_reg;
   logic pinMeta_reg;
   logic pinSync_reg;
   logic micClkPrev_reg;
   logic micRise_reg;
   logic micFall_reg;
   logic bitClkIn_reg;
   logic pinOut_reg;
   logic pinOeN_reg;
   logic pending_reg;
   logic [spfs_pkg::CNT_W-1:0] cnt_reg;
   spfs_pkg::spfs_state_e state_reg;
   spfs_pkg::spfs_state_e state_next;
   logic [spfs_pkg::CNT_W-1:0] cnt_next;
   logic pending_next;

   // Register decode
   wire ctrlWr = regWrEn && (regAddr == spfs_pkg::CTRL_ADDR);
   wire ctrlRd = regRdEn && (regAddr == spfs_pkg::CTRL_ADDR);
   wire flagsRd = regRdEn && (regAddr == spfs_pkg::FLAGS_ADDR);
   wire [7:0] ctrlNext = regWrData & spfs_pkg::CTRL_WR_MASK;
   wire [7:0] rdView = {ctrl_reg[spfs_pkg::FUNC_MSB:spfs_pkg::OUT_BIT], pinSync_reg,
                        ctrl_reg[spfs_pkg::DUR_BIT], 1'b0};
   wire [7:0] rdNext = ctrlRd ? rdView : 8'h00;

   // Mode decode
   wire [3:0] fn = ctrl_reg[spfs_pkg::FUNC_MSB:spfs_pkg::FUNC_LSB];
   wire repeatMode = ctrl_reg[spfs_pkg::DUR_BIT];
   wire gpOutMode = (fn == spfs_pkg::FN_GP_OUT);
   wire bitClkMode = (fn == spfs_pkg::FN_BIT_CLK);
   wire micMode = (fn >= spfs_pkg::FN_MIC_LO) && (fn <= spfs_pkg::FN_MIC_HI);
   wire irqMode = (fn == spfs_pkg::FN_HEADSET) || (fn >= spfs_pkg::FN_HS_BTN);
   wire trigger = irqSelect(fn, headsetIrq, buttonIrq, shortIrq, noiseIrq);
   wire [spfs_pkg::CNT_W-1:0] lenHeadset = spfs_pkg::CNT_W'(HEADSET_LEN - 1);
   wire [spfs_pkg::CNT_W-1:0] lenPulse = spfs_pkg::CNT_W'(PULSE_LEN - 1);
   wire [spfs_pkg::CNT_W-1:0] lastCnt = (fn == spfs_pkg::FN_HEADSET) ? lenHeadset : lenPulse;
   wire atLast = (cnt_reg == lastCnt);
   wire irqActive = (state_reg == spfs_pkg::ST_PULSE);

   // Pin drive selection
   wire bitClkDrive = bitClkMode && bitClkMaster;
   wire pinLevelNext = gpOutMode ? ctrl_reg[spfs_pkg::OUT_BIT] :
                       bitClkMode ? bitClkOut : (irqMode & irqActive);
   wire pinOeNNext = !(gpOutMode || bitClkDrive || irqMode);

   // Microphone clock edges
   wire micEdgeRise = micClk && !micClkPrev_reg;
   wire micEdgeFall = !micClk && micClkPrev_reg;

   // Pending repeat request; an event beats a flags read
   always_comb
   begin
      pending_next = pending_reg;
      if (!irqMode || !repeatMode)
      begin
         pending_next = 1'b0;
      end
      else if (trigger)
      begin
         pending_next = 1'b1;
      end
      else if (flagsRd)
      begin
         pending_next = 1'b0;
      end
   end

   // Pulse sequencer
   always_comb
   begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      unique case (state_reg)
         spfs_pkg::ST_IDLE:
         begin
            cnt_next = '0;
            if (irqMode && trigger)
            begin
               state_next = spfs_pkg::ST_PULSE;
            end
         end
         spfs_pkg::ST_PULSE:
         begin
            cnt_next = cnt_reg + 1'b1;
            if (atLast)
            begin
               cnt_next = '0;
               state_next = pending_next ? spfs_pkg::ST_GAP : spfs_pkg::ST_IDLE;
            end
         end
         spfs_pkg::ST_GAP:
         begin
            cnt_next = cnt_reg + 1'b1;
            if (atLast)
            begin
               cnt_next = '0;
               state_next = pending_next ? spfs_pkg::ST_PULSE : spfs_pkg::ST_IDLE;
            end
         end
      endcase
      if (!irqMode)
      begin
         state_next = spfs_pkg::ST_IDLE;
         cnt_next = '0;
      end
   end

   // Control register; bit 0 and bit 2 are never stored
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         ctrl_reg <= spfs_pkg::CTRL_RESET;
      end
      else if (clkEn && ctrlWr)
      begin
         ctrl_reg <= ctrlNext;
      end
   end

   // Read data and pin synchroniser
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         rdData_reg <= 8'h00;
         pinMeta_reg <= 1'b0;
         pinSync_reg <= 1'b0;
      end
      else if (clkEn)
      begin
         rdData_reg <= rdNext;
         pinMeta_reg <= pinIn;
         pinSync_reg <= pinMeta_reg;
      end
   end

   // Microphone capture and bit clock input
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         micClkPrev_reg <= 1'b0;
         micRise_reg <= 1'b0;
         micFall_reg <= 1'b0;
         bitClkIn_reg <= 1'b0;
      end
      else if (clkEn)
      begin
         micClkPrev_reg <= micClk;
         if (micMode && micEdgeRise)
         begin
            micRise_reg <= pinSync_reg;
         end
         if (micMode && micEdgeFall)
         begin
            micFall_reg <= pinSync_reg;
         end
         bitClkIn_reg <= bitClkMode && !bitClkMaster && pinSync_reg;
      end
   end

   // Sequencer and pin drive registers
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state_reg <= spfs_pkg::ST_IDLE;
         cnt_reg <= '0;
         pending_reg <= 1'b0;
         pinOut_reg <= 1'b0;
         pinOeN_reg <= 1'b1;
      end
      else if (clkEn)
      begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         pending_reg <= pending_next;
         pinOut_reg <= pinLevelNext;
         pinOeN_reg <= pinOeNNext;
      end
   end

   assign regRdData = rdData_reg;
   assign micDataRise = micRise_reg;
   assign micDataFall = micFall_reg;
   assign bitClkIn = bitClkIn_reg;
   assign pinOut = pinOut_reg;
   assign pinOeN = pinOeN_reg;

   // Checks on the pin selector
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   sequence s_pulseStart;
      clkEn && (state_reg == spfs_pkg::ST_IDLE) && irqMode && trigger;
   endsequence

   sequence s_pulseEnd;
      clkEn && irqActive && atLast && !pending_next;
   endsequence

   a_disabled_hiz: assert property ((clkEn && fn == spfs_pkg::FN_DISABLED) |=> pinOeN)
      else $error("pin driven while disabled");
   a_input_hiz: assert property ((clkEn && isInputFn(fn)) |=> pinOeN)
      else $error("pin driven in an input function");
   a_gpout_level: assert property ((clkEn && gpOutMode) |=> (!pinOeN && pinOut == $past(ctrl_reg[spfs_pkg::OUT_BIT])))
      else $error("output level does not follow bit 3");
   a_gpin_read: assert property ((clkEn && ctrlRd) |=> (regRdData[2] == $past(pinSync_reg)))
      else $error("input bit does not show pin level");
   a_rsvd_zero: assert property (regRdData[0] == 1'b0)
      else $error("reserved bit reads as one");
   a_irq_start: assert property (s_pulseStart |=> (irqActive ##1 (!clkEn || pinOut)))
      else $error("selected interrupt did not start a pulse");
   a_pulse_len: assert property (irqActive |-> (cnt_reg <= lastCnt))
      else $error("interrupt pulse longer than its length");
   a_single_stop: assert property ((s_pulseEnd and (!repeatMode)) |=> (state_reg == spfs_pkg::ST_IDLE))
      else $error("single pulse mode repeated");
   a_repeat_gap: assert property ((clkEn && irqActive && atLast && pending_next) |=> (state_reg == spfs_pkg::ST_GAP))
      else $error("repeat mode did not schedule another pulse");
   a_flags_stop: assert property ((clkEn && flagsRd && !trigger) |=> !pending_reg)
      else $error("flags read did not end repetition");
   a_mic_rise: assert property ((clkEn && micMode && micEdgeRise) |=> (micDataRise == $past(pinSync_reg)))
      else $error("microphone rising capture wrong");
   a_bitclk_out: assert property ((clkEn && bitClkDrive) |=> (!pinOeN && pinOut == $past(bitClkOut)))
      else $error("bit clock not driven in master direction");

endmodule

`default_nettype wire

// *** testbench/spfs_pin_load.sv ***
// Pad load model for the second multi-function pin: an external driver
// and the wire between it and the block. Assumes the bench sets extDrive
// and extLevel on clk.
`default_nettype none
module spfs_pin_load
(
   input wire logic clk,
   input wire logic pinOut,
   input wire logic pinOeN,
   input wire logic extDrive,
   input wire logic extLevel,
   output logic pinIn,
   output logic clash
);
   timeunit 1ns;
   timeprecision 1ns;
   logic flipReg = 1'b0;
   logic seenReg = 1'b0;
   // Floating pad wobbles, so a stale level is never trusted
   always @(posedge clk)
      flipReg <= ~flipReg;
   // Pad level from whoever drives it
   assign pinIn = !pinOeN ? pinOut : (extDrive ? extLevel : flipReg);
   assign clash = seenReg;
   // Sticky flag when both sides drive the pad
   always @(posedge clk)
      if (!pinOeN && extDrive)
         seenReg <= 1'b1;
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
// Self-checking bench for the second multi-function pin selector.
// Assumes spfs_pin_ctrl and the spfs_pin_load pad model.
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int HL = 8;
   localparam int PL = 10;
   logic clk = 1'b0;
   logic sysRst = 1'b1;
   logic clkEn = 1'b1;
   logic [7:0] regAddr = 8'h00;
   logic regWrEn = 1'b0;
   logic [7:0] regWrData = 8'h00;
   logic regRdEn = 1'b0;
   logic [3:0] irq = 4'h0; // Headset, button, short, noise
   logic micClk = 1'b0;
   logic bitClkOut = 1'b0;
   logic bitClkMaster = 1'b0;
   logic extDrive = 1'b0;
   logic extLevel = 1'b0;
   logic [7:0] regRdData;
   logic micDataRise, micDataFall, bitClkIn, pinIn, pinOut, pinOeN, clash;
   int failures = 0;
   int checked = 0;
   int rises, highs, len;
   // Function code in the top nibble, expected source mask below
   logic [7:0] rows [8] = '{8'h28, 8'h9C, 8'hAF, 8'hB3, 8'hC6, 8'hD2, 8'hE1, 8'hF4};

   spfs_pin_ctrl #(.HEADSET_LEN(HL), .PULSE_LEN(PL)) u_spfs_pin_ctrl
   (
      .clk(clk), .sys_rst(sysRst), .clkEn(clkEn), .regAddr(regAddr), .regWrEn(regWrEn),
      .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData), .headsetIrq(irq[3]),
      .buttonIrq(irq[2]), .shortIrq(irq[1]), .noiseIrq(irq[0]), .micClk(micClk),
      .micDataRise(micDataRise), .micDataFall(micDataFall), .bitClkOut(bitClkOut),
      .bitClkMaster(bitClkMaster), .bitClkIn(bitClkIn), .pinIn(pinIn), .pinOut(pinOut), .pinOeN(pinOeN)
   );
   spfs_pin_load u_spfs_pin_load
   (
      .clk(clk), .pinOut(pinOut), .pinOeN(pinOeN), .extDrive(extDrive), .extLevel(extLevel),
      .pinIn(pinIn), .clash(clash)
   );

   // Free-running core clock
   always #20 clk = ~clk;

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp)
      begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      regAddr <= a;
      regWrData <= d;
      regWrEn <= 1'b1;
      @(posedge clk);
      regWrEn <= 1'b0;
   endtask

   task automatic setFn(input logic [7:0] d);
      wrReg(spfs_pkg::CTRL_ADDR, d); // never code one, bit 0 kept clear
   endtask

   task automatic rdReg(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      regAddr <= a;
      regRdEn <= 1'b1;
      @(posedge clk);
      regRdEn <= 1'b0;
      #1 check("read data", regRdData, exp);
   endtask

   task automatic drive(input logic lvl);
      @(posedge clk);
      extDrive <= 1'b1;
      extLevel <= lvl;
   endtask

   task automatic fire(input logic [3:0] m);
      @(posedge clk);
      irq <= m;
      @(posedge clk);
      irq <= 4'h0;
   endtask

   // Counts pulses and high cycles on the pad over n edges
   task automatic watch(input int n);
      logic prev;
      #1 prev = pinOut;
      rises = 0;
      highs = 0;
      repeat (n)
      begin
         @(posedge clk);
         #1 highs += (pinOut === 1'b1);
         rises += (pinOut === 1'b1 && prev !== 1'b1);
         prev = pinOut;
      end
   endtask

   task automatic give_verdict;
      $display("checks %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // Main sequence
   initial
   begin
      step(16);
      sysRst <= 1'b0;
      for (int r = 0; r < 8; r++)
         for (int s = 0; s < 4; s++)
         begin
            setFn({rows[r][7:4], 4'h0});
            fire(4'h8 >> s);
            watch(3 * PL + 6);
            len = (rows[r][7:4] == 4'h2) ? HL : PL;
            check("pulse count", 8'(rises), 8'(rows[r][3 - s]));
            check("pulse width", 8'(highs), rows[r][3 - s] ? 8'(len) : 8'h00);
         end
      setFn(8'h44);
      step(3);
      #1 check("gp out low", {pinOut, pinOeN}, 8'h00);
      rdReg(spfs_pkg::CTRL_ADDR, 8'h40);
      setFn(8'h4A);
      step(3);
      #1 check("gp out high", {pinOut, pinOeN}, 8'h02);
      rdReg(spfs_pkg::CTRL_ADDR, 8'h4E);
      @(posedge clk);
      clkEn <= 1'b0;
      setFn(8'h40);
      @(posedge clk);
      clkEn <= 1'b1;
      wrReg(8'h64, 8'h00);
      rdReg(8'h64, 8'h00);
      rdReg(spfs_pkg::CTRL_ADDR, 8'h4E);
      setFn(8'h30);
      step(2);
      drive(1'b1);
      step(4);
      #1 check("input hi-z", 8'(pinOeN), 8'h01);
      rdReg(spfs_pkg::CTRL_ADDR, 8'h34);
      drive(1'b0);
      step(4);
      rdReg(spfs_pkg::CTRL_ADDR, 8'h30);
      for (int i = 0; i < 3; i++)
      begin
         setFn({4'(5 + i), 4'h0});
         drive(i[0]);
         step(4);
         @(posedge clk);
         micClk <= 1'b1;
         step(4);
         drive(!i[0]);
         step(4);
         @(posedge clk);
         micClk <= 1'b0;
         step(4);
         #1 check("mic rise", 8'(micDataRise), 8'(i % 2));
         check("mic fall", {micDataFall, pinOeN}, {6'h00, !i[0], 1'b1});
      end
      setFn(8'h80);
      step(5);
      #1 check("bit clock in", {bitClkIn, pinOeN}, 8'h03);
      @(posedge clk);
      extDrive <= 1'b0;
      bitClkMaster <= 1'b1;
      bitClkOut <= 1'b1;
      step(4);
      #1 check("bit clock out", {pinOut, pinOeN}, 8'h02);
      setFn(8'hD2);
      fire(4'h2);
      watch(4 * PL);
      check("repeat pulses", {8'(rises), 8'(highs)} >> 0 == {8'h02, 8'(2 * PL)} ? 8'h01 : 8'h00, 8'h01);
      rdReg(spfs_pkg::FLAGS_ADDR, 8'h00);
      watch(3 * PL);
      check("after flags read", {8'(rises), 8'(highs)} == {8'h00, 8'(PL - 2)} ? 8'h01 : 8'h00, 8'h01);
      // Pull the pad low so the synchronised level after reset is known
      @(posedge clk);
      sysRst <= 1'b1;
      extDrive <= 1'b1;
      extLevel <= 1'b0;
      step(2);
      #1 check("in reset", {regRdData[0], pinOut, pinOeN}, 8'h01);
      @(posedge clk);
      sysRst <= 1'b0;
      rdReg(spfs_pkg::CTRL_ADDR, 8'h00);
      check("reset hi-z", 8'(pinOeN), 8'h01);
      check("pad contention", 8'(clash), 8'h00);
      give_verdict();
   end

   // Watchdog against a hang
   initial
   begin
      #400000;
      failures++;
      give_verdict();
   end
endmodule
`default_nettype wire
